/* File: common/sbr_pkg.sv */
`default_nettype none
package sbr_pkg;
    // -------------------------------------------------------------
    // Register widths
    // -------------------------------------------------------------
    localparam int IR_W  = 3;
    localparam int ID_W  = 32;
    localparam int PIN_N = 16;
    localparam int FIX_N = 4;
    localparam int BSR_W = PIN_N + FIX_N;

    // -------------------------------------------------------------
    // Instruction codes
    // -------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
    localparam logic [IR_W-1:0] IR_IDCODE  = 3'h1;
    localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] IR_RSVD_A  = 3'h3;
    localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h4;
    localparam logic [IR_W-1:0] IR_PRIVATE = 3'h5;
    localparam logic [IR_W-1:0] IR_RSVD_B  = 3'h6;
    localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

    // -------------------------------------------------------------
    // Reset and default values
    // -------------------------------------------------------------
    // Identification value is arbitrary; bit 0 kept at one
    localparam logic [ID_W-1:0]  ID_VALUE    = 32'h0A5C_3E61;
    localparam logic [FIX_N-1:0] FIX_DEFAULT = 4'hF;
    localparam int               TLR_ONES    = 5;

    // -------------------------------------------------------------
    // Controller states
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR    = 4'h0, ST_RTI    = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
        ST_SH_DR  = 4'h6, ST_EX1_DR = 4'h7, ST_PS_DR  = 4'h5, ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hC, ST_SEL_IR = 4'hD, ST_CAP_IR = 4'hF, ST_SH_IR  = 4'hE,
        ST_EX1_IR = 4'hA, ST_PS_IR  = 4'hB, ST_EX2_IR = 4'h9, ST_UPD_IR = 4'h8
    } sbr_state_t;
endpackage
`default_nettype wire

/* File: common/sbr_tap_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sbr_tap_if;
    sbr_pkg::sbr_state_t state;
    modport ctrl (output state);
    modport core (input state);
endinterface
`default_nettype wire

/* File: core/sbr_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module sbr_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // -------------------------------------------------------------
    // Two stages; first stage feeds only the second
    // -------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_reg <= '0;
            q_reg    <= '0;
        end
        else if (i_en)
        begin
            meta_reg <= i_d;
            q_reg    <= meta_reg;
        end
    end

    assign o_q = q_reg;
endmodule
`default_nettype wire

/* File: core/sbr_tap_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module sbr_tap_ctrl (
    input  wire logic  i_tck,
    input  wire logic  i_reset_n,
    input  wire logic  i_tms,
    sbr_tap_if.ctrl    tap
);
    sbr_pkg::sbr_state_t state_reg;
    sbr_pkg::sbr_state_t state_next;

    // -------------------------------------------------------------
    // Sixteen-state sequencer
    // -------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            sbr_pkg::ST_TLR:    state_next = i_tms ? sbr_pkg::ST_TLR    : sbr_pkg::ST_RTI;
            sbr_pkg::ST_RTI:    state_next = i_tms ? sbr_pkg::ST_SEL_DR : sbr_pkg::ST_RTI;
            sbr_pkg::ST_SEL_DR: state_next = i_tms ? sbr_pkg::ST_SEL_IR : sbr_pkg::ST_CAP_DR;
            sbr_pkg::ST_CAP_DR: state_next = i_tms ? sbr_pkg::ST_EX1_DR : sbr_pkg::ST_SH_DR;
            sbr_pkg::ST_SH_DR:  state_next = i_tms ? sbr_pkg::ST_EX1_DR : sbr_pkg::ST_SH_DR;
            sbr_pkg::ST_EX1_DR: state_next = i_tms ? sbr_pkg::ST_UPD_DR : sbr_pkg::ST_PS_DR;
            sbr_pkg::ST_PS_DR:  state_next = i_tms ? sbr_pkg::ST_EX2_DR : sbr_pkg::ST_PS_DR;
            sbr_pkg::ST_EX2_DR: state_next = i_tms ? sbr_pkg::ST_UPD_DR : sbr_pkg::ST_SH_DR;
            sbr_pkg::ST_UPD_DR: state_next = i_tms ? sbr_pkg::ST_SEL_DR : sbr_pkg::ST_RTI;
            sbr_pkg::ST_SEL_IR: state_next = i_tms ? sbr_pkg::ST_TLR    : sbr_pkg::ST_CAP_IR;
            sbr_pkg::ST_CAP_IR: state_next = i_tms ? sbr_pkg::ST_EX1_IR : sbr_pkg::ST_SH_IR;
            sbr_pkg::ST_SH_IR:  state_next = i_tms ? sbr_pkg::ST_EX1_IR : sbr_pkg::ST_SH_IR;
            sbr_pkg::ST_EX1_IR: state_next = i_tms ? sbr_pkg::ST_UPD_IR : sbr_pkg::ST_PS_IR;
            sbr_pkg::ST_PS_IR:  state_next = i_tms ? sbr_pkg::ST_EX2_IR : sbr_pkg::ST_PS_IR;
            sbr_pkg::ST_EX2_IR: state_next = i_tms ? sbr_pkg::ST_UPD_IR : sbr_pkg::ST_SH_IR;
            sbr_pkg::ST_UPD_IR: state_next = i_tms ? sbr_pkg::ST_SEL_DR : sbr_pkg::ST_RTI;
            default:            state_next = sbr_pkg::ST_TLR;
        endcase
    end

    // Power-up lands in reset state
    always_ff @(posedge i_tck or negedge i_reset_n)
    begin
        if (!i_reset_n)
            state_reg <= sbr_pkg::ST_TLR;
        else
            state_reg <= state_next;
    end

    assign tap.state = state_reg;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    property p_five_ones;
        @(posedge i_tck) disable iff (!i_reset_n)
        i_tms [*5] |=> (state_reg == sbr_pkg::ST_TLR);
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("five ones miss reset");

    property p_rti_hold;
        @(posedge i_tck) disable iff (!i_reset_n)
        (state_reg == sbr_pkg::ST_RTI) && !i_tms |=> (state_reg == sbr_pkg::ST_RTI);
    endproperty
    a_rti_hold: assert property (p_rti_hold) else $error("idle not held");
endmodule
`default_nettype wire

/* File: core/sbr_tap_core.sv */
// Behaviour
// - Capture-instruction loads 01 into the two low instruction bits.
// - Shift-instruction moves instruction bits from serial in to serial out.
// - Shifted instruction takes effect only at update-instruction.
// - Codes are binary, LSB shifted first in and first out.
// - Code 000 is external test; memory inputs are never blocked.
// - External test drives scan contents onto outputs at falling edge in update; here o_mem_drive follows later, through the handshake on the memory clock.
// - External test capture loads pin states; pinless cells take defaults.
// - Code 001 captures fixed 32-bit identification and shifts it out.
// - Identification is active after power-up and in reset state.
// - Code 100 sample/preload captures input and I/O buffer states.
// - Pinless scan cells capture their fixed default, not a pin.
// - After sample capture, shift-data puts scan register on the serial path.
// - Code 010 floats memory outputs, captures ring, shifts scan register.
// - Code 111 puts the one-bit bypass on the serial path.
// - Reserved codes 011 and 110 behave exactly as bypass.
// - Instruction register is three bits wide.
// - Identification is 32 bits; bit 0 leaves first.
// - Five rising edges with mode select high, or power-up, reset controller.
// - Undriven mode select and serial data read as one.
`timescale 1ns/10ps
`default_nettype none
module sbr_tap_core (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_reset_n,
    input  wire logic                      i_clk_en,
    input  wire logic                      i_tck,
    input  wire logic                      i_tms,
    input  wire logic                      i_tms_driven,
    input  wire logic                      i_tdi,
    input  wire logic                      i_tdi_driven,
    input  wire logic [sbr_pkg::PIN_N-1:0] i_mem_pins,
    output var  logic                      o_tdo,
    output var  logic                      o_tdo_oe,
    output var  logic                      o_mem_override,
    output var  logic                      o_mem_hiz,
    output var  logic [sbr_pkg::PIN_N-1:0] o_mem_drive
);
    localparam int PN = sbr_pkg::PIN_N;
    localparam int BW = sbr_pkg::BSR_W;
    localparam int IW = sbr_pkg::IR_W;

    sbr_tap_if tap ();

    logic          tms_lvl;
    logic          tdi_lvl;
    logic [PN-1:0] pins_s;
    logic          st_cap_dr;
    logic          st_sh_dr;
    logic          st_upd_dr;
    logic          st_cap_ir;
    logic          st_sh_ir;
    logic          sel_bsr;
    logic          sel_id;

    // -------------------------------------------------------------
    // Pin levels and state decode
    // -------------------------------------------------------------
    // Pad pull-ups: a floating pin reads high
    assign tms_lvl = i_tms_driven ? i_tms : 1'b1;
    assign tdi_lvl = i_tdi_driven ? i_tdi : 1'b1;

    sbr_tap_ctrl u_ctrl (
        .i_tck     (i_tck),
        .i_reset_n (i_reset_n),
        .i_tms     (tms_lvl),
        .tap       (tap.ctrl)
    );

    // Ring sampled through two stages; tester keeps it still
    sbr_sync2 #(.W(PN)) u_pin_sync (
        .i_clk     (i_tck),
        .i_reset_n (i_reset_n),
        .i_en      (1'b1),
        .i_d       (i_mem_pins),
        .o_q       (pins_s)
    );

    assign st_cap_dr = (tap.state == sbr_pkg::ST_CAP_DR);
    assign st_sh_dr  = (tap.state == sbr_pkg::ST_SH_DR);
    assign st_upd_dr = (tap.state == sbr_pkg::ST_UPD_DR);
    assign st_cap_ir = (tap.state == sbr_pkg::ST_CAP_IR);
    assign st_sh_ir  = (tap.state == sbr_pkg::ST_SH_IR);

    // -------------------------------------------------------------
    // Rising-edge shift registers
    // -------------------------------------------------------------
    logic [IW-1:0]               ir_sh_reg;
    logic [IW-1:0]               ir_sh_next;
    logic [sbr_pkg::ID_W-1:0]    id_reg;
    logic [sbr_pkg::ID_W-1:0]    id_next;
    logic [BW-1:0]               bsr_reg;
    logic [BW-1:0]               bsr_next;
    logic                        byp_reg;
    logic                        byp_next;
    logic [IW-1:0]               ir_act_reg;

    always_comb
    begin
        ir_sh_next = ir_sh_reg;
        id_next    = id_reg;
        bsr_next   = bsr_reg;
        byp_next   = byp_reg;
        if (st_cap_ir)
            ir_sh_next = sbr_pkg::IR_CAPTURE;
        else if (st_sh_ir)
            ir_sh_next = {tdi_lvl, ir_sh_reg[IW-1:1]};
        if (st_cap_dr)
        begin
            if (sel_bsr)
                bsr_next = {sbr_pkg::FIX_DEFAULT, pins_s};
            else if (sel_id)
                id_next = sbr_pkg::ID_VALUE;
            else
                byp_next = 1'b0;
        end
        else if (st_sh_dr)
        begin
            if (sel_bsr)
                bsr_next = {tdi_lvl, bsr_reg[BW-1:1]};
            else if (sel_id)
                id_next = {tdi_lvl, id_reg[sbr_pkg::ID_W-1:1]};
            else
                byp_next = tdi_lvl;
        end
    end

    always_ff @(posedge i_tck or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ir_sh_reg <= sbr_pkg::IR_CAPTURE;
            id_reg    <= sbr_pkg::ID_VALUE;
            bsr_reg   <= '0;
            byp_reg   <= 1'b0;
        end
        else
        begin
            ir_sh_reg <= ir_sh_next;
            id_reg    <= id_next;
            bsr_reg   <= bsr_next;
            byp_reg   <= byp_next;
        end
    end

    // -------------------------------------------------------------
    // Instruction decode
    // -------------------------------------------------------------
    // Unlisted codes fall to bypass
    always_comb
    begin
        sel_bsr = 1'b0;
        sel_id  = 1'b0;
        case (ir_act_reg)
            sbr_pkg::IR_EXTEST:  sel_bsr = 1'b1;
            sbr_pkg::IR_SAMPLEZ: sel_bsr = 1'b1;
            sbr_pkg::IR_SAMPLE:  sel_bsr = 1'b1;
            sbr_pkg::IR_IDCODE:  sel_id  = 1'b1;
            default:             sel_bsr = 1'b0;
        endcase
    end

    // -------------------------------------------------------------
    // Falling-edge update and serial out
    // -------------------------------------------------------------
    logic [IW-1:0] ir_act_next;
    logic [PN-1:0] upd_reg;
    logic [PN-1:0] upd_next;
    logic          tdo_reg;
    logic          tdo_next;
    logic          oe_reg;
    logic          oe_next;

    always_comb
    begin
        ir_act_next = ir_act_reg;
        upd_next    = upd_reg;
        oe_next     = st_sh_ir | st_sh_dr;
        tdo_next    = tdo_reg;
        if (tap.state == sbr_pkg::ST_TLR)
            ir_act_next = sbr_pkg::IR_IDCODE;
        else if (tap.state == sbr_pkg::ST_UPD_IR)
            ir_act_next = ir_sh_reg;
        if (st_upd_dr && sel_bsr)
            upd_next = bsr_reg[PN-1:0];
        if (st_sh_ir)
            tdo_next = ir_sh_reg[0];
        else if (st_sh_dr && sel_bsr)
            tdo_next = bsr_reg[0];
        else if (st_sh_dr && sel_id)
            tdo_next = id_reg[0];
        else if (st_sh_dr)
            tdo_next = byp_reg;
    end

    // Outputs change on the falling edge, giving the tester half a period
    always_ff @(negedge i_tck or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ir_act_reg <= sbr_pkg::IR_IDCODE;
            upd_reg    <= '0;
            tdo_reg    <= 1'b0;
            oe_reg     <= 1'b0;
        end
        else
        begin
            ir_act_reg <= ir_act_next;
            upd_reg    <= upd_next;
            tdo_reg    <= tdo_next;
            oe_reg     <= oe_next;
        end
    end

    assign o_tdo    = tdo_reg;
    assign o_tdo_oe = oe_reg;

    // -------------------------------------------------------------
    // Handshake of update word toward the memory clock
    // -------------------------------------------------------------
    // Needs a few further test clocks after update to complete
    logic          ext_lvl;
    logic          hiz_lvl;
    logic          pend_reg;
    logic          pend_next;
    logic          req_reg;
    logic          req_next;
    logic [PN-1:0] xfer_reg;
    logic [PN-1:0] xfer_next;
    logic          ack_s;

    always_comb
    begin
        pend_next = pend_reg;
        req_next  = req_reg;
        xfer_next = xfer_reg;
        if (pend_reg && (req_reg == ack_s))
        begin
            xfer_next = upd_reg;
            req_next  = ~req_reg;
            pend_next = 1'b0;
        end
        // A new update beats the clear
        if (st_upd_dr && sel_bsr)
            pend_next = 1'b1;
    end

    always_ff @(posedge i_tck or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pend_reg <= 1'b0;
            req_reg  <= 1'b0;
            xfer_reg <= '0;
        end
        else
        begin
            pend_reg <= pend_next;
            req_reg  <= req_next;
            xfer_reg <= xfer_next;
        end
    end

    assign ext_lvl = (ir_act_reg == sbr_pkg::IR_EXTEST);
    assign hiz_lvl = (ir_act_reg == sbr_pkg::IR_SAMPLEZ);

    // -------------------------------------------------------------
    // Memory clock side
    // -------------------------------------------------------------
    logic [2:0]    lvl_s;
    logic          ack_reg;
    logic          ack_next;
    logic [PN-1:0] drv_reg;
    logic [PN-1:0] drv_next;
    logic          ovr_reg;
    logic          hiz_reg;

    sbr_sync2 #(.W(3)) u_ref_sync (
        .i_clk     (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_en      (i_clk_en),
        .i_d       ({req_reg, hiz_lvl, ext_lvl}),
        .o_q       (lvl_s)
    );

    sbr_sync2 #(.W(1)) u_ack_sync (
        .i_clk     (i_tck),
        .i_reset_n (i_reset_n),
        .i_en      (1'b1),
        .i_d       (ack_reg),
        .o_q       (ack_s)
    );

    always_comb
    begin
        ack_next = lvl_s[2];
        drv_next = drv_reg;
        if (lvl_s[2] != ack_reg)
            drv_next = xfer_reg;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ack_reg <= 1'b0;
            drv_reg <= '0;
            ovr_reg <= 1'b0;
            hiz_reg <= 1'b0;
        end
        else if (i_clk_en)
        begin
            ack_reg <= ack_next;
            drv_reg <= drv_next;
            ovr_reg <= lvl_s[0];
            hiz_reg <= lvl_s[1];
        end
    end

    // Only output drivers are taken over; input path stays live
    assign o_mem_override = ovr_reg;
    assign o_mem_hiz      = hiz_reg;
    assign o_mem_drive    = drv_reg;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    property p_cap_ir;
        @(posedge i_tck) disable iff (!i_reset_n)
        st_cap_ir |=> (ir_sh_reg[1:0] == 2'h1);
    endproperty
    a_cap_ir: assert property (p_cap_ir) else $error("capture-ir value wrong");

    property p_sh_ir;
        @(posedge i_tck) disable iff (!i_reset_n)
        st_sh_ir |=> (ir_sh_reg == {$past(tdi_lvl), $past(ir_sh_reg[2:1])});
    endproperty
    a_sh_ir: assert property (p_sh_ir) else $error("ir shift order wrong");

    property p_ir_hold;
        @(posedge i_tck) disable iff (!i_reset_n)
        (tap.state != sbr_pkg::ST_UPD_IR) && (tap.state != sbr_pkg::ST_TLR)
            |-> $stable(ir_act_reg);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("instruction changed early");

    property p_tlr_id;
        @(posedge i_tck) disable iff (!i_reset_n)
        (tap.state == sbr_pkg::ST_TLR) |=> (ir_act_reg == sbr_pkg::IR_IDCODE);
    endproperty
    a_tlr_id: assert property (p_tlr_id) else $error("reset lost identification");

    property p_cap_id;
        @(posedge i_tck) disable iff (!i_reset_n)
        st_cap_dr && sel_id |=> (id_reg == sbr_pkg::ID_VALUE);
    endproperty
    a_cap_id: assert property (p_cap_id) else $error("id capture wrong");

    property p_cap_bsr;
        @(posedge i_tck) disable iff (!i_reset_n)
        st_cap_dr && sel_bsr |=> (bsr_reg == {sbr_pkg::FIX_DEFAULT, $past(pins_s)});
    endproperty
    a_cap_bsr: assert property (p_cap_bsr) else $error("scan capture wrong");

    property p_byp;
        @(posedge i_tck) disable iff (!i_reset_n)
        st_sh_dr && !sel_bsr && !sel_id |=> (byp_reg == $past(tdi_lvl));
    endproperty
    a_byp: assert property (p_byp) else $error("bypass path wrong");

    property p_upd;
        @(posedge i_tck) disable iff (!i_reset_n)
        st_upd_dr && sel_bsr |=> (upd_reg == $past(bsr_reg[PN-1:0]));
    endproperty
    a_upd: assert property (p_upd) else $error("update word not loaded");
endmodule
`default_nettype wire

/* File: testbench/sbr_tester.sv */
`timescale 1ns/10ps
`default_nettype none
module sbr_tester (
    output var  logic o_tck,
    output var  logic o_tms,
    output var  logic o_tdi,
    input  wire logic i_tdo
);
    // ------------------------------------
    // Scan controller side
    // ------------------------------------
    // Test clock stands low between frames
    logic b;

    initial
    begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end

    // One 32 ns test clock; out bit taken before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        #7;
        o_tms = tms;
        o_tdi = tdi;
        #9;
        tdo = i_tdo;
        o_tck = 1'b1;
        #16;
        o_tck = 1'b0;
    endtask

    task automatic go_ir();
        step(1'b1, o_tdi, b);
        step(1'b1, o_tdi, b);
        step(1'b0, o_tdi, b);
        step(1'b0, o_tdi, b);
    endtask

    task automatic go_dr();
        step(1'b1, o_tdi, b);
        step(1'b0, o_tdi, b);
        step(1'b0, o_tdi, b);
    endtask

    task automatic sh(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'h0;
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
    endtask

    // Update, then idle clocks so the memory side gets its word
    task automatic fin();
        step(1'b1, o_tdi, b);
        repeat (4) step(1'b0, o_tdi, b);
        o_tdi = ~o_tdi;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ------------------------------------
    // Bench signals and instances
    // ------------------------------------
    logic        ref_clk;
    logic        reset_n;
    logic        clk_en;
    logic        tms_drv;
    logic        tdi_drv;
    logic [15:0] pins;
    logic [31:0] r;
    logic        b;
    int          bad_count;
    int          compares;
    wire logic   tck;
    wire logic   tms;
    wire logic   tdi;
    wire logic   tdo;
    wire logic   tdo_oe;
    wire logic   ovr;
    wire logic   hiz;
    wire logic [15:0] drv;

    sbr_tester tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));

    sbr_tap_core dut (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_clk_en(clk_en),
        .i_tck(tck), .i_tms(tms), .i_tms_driven(tms_drv), .i_tdi(tdi),
        .i_tdi_driven(tdi_drv), .i_mem_pins(pins), .o_tdo(tdo),
        .o_tdo_oe(tdo_oe), .o_mem_override(ovr), .o_mem_hiz(hiz),
        .o_mem_drive(drv)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ------------------------------------
    // Helpers
    // ------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Memory side needs a few reference clocks after the handshake
    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic load(input logic [2:0] code);
        tester.go_ir();
        tester.sh(3, {29'h0, code}, r);
        tester.fin();
        chk({29'h0, r[2:0]}, 32'h1, "ir capture");
    endtask

    // Pins held steady over the capture edge
    task automatic set_pins(input logic [15:0] v);
        @(posedge ref_clk) pins <= v;
        settle();
        tester.step(1'b0, 1'b1, b);
        tester.step(1'b0, 1'b1, b);
    endtask

    task automatic dr(input int n, input logic [31:0] din);
        tester.go_dr();
        @(posedge ref_clk);
        chk({31'h0, tdo_oe}, 32'h1, "oe in shift");
        tester.sh(n, din, r);
        tester.fin();
        settle();
        chk({31'h0, tdo_oe}, 32'h0, "oe idle");
    endtask

    // ------------------------------------
    // Scenarios
    // ------------------------------------
    task automatic t_id();
        dr(32, 32'h0);
        chk(r, sbr_pkg::ID_VALUE, "id");
        chk({30'h0, ovr, hiz}, 32'h0, "idle outputs");
        $display("test id done");
    endtask

    task automatic t_bypass();
        logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
        foreach (codes[i])
        begin
            load(codes[i]);
            dr(8, 32'hB4);
            chk({24'h0, r[7:0]}, 32'h68, "bypass");
            chk({30'h0, ovr, hiz}, 32'h0, "bypass outputs");
        end
        $display("test bypass done");
    endtask

    task automatic t_sample_extest();
        set_pins(16'hA5C3);
        load(3'h4);
        dr(20, 32'hF3C96);
        chk({12'h0, r[19:0]}, 32'hFA5C3, "sample");
        tester.go_ir();
        tester.sh(3, 32'h0, r);
        settle();
        chk({31'h0, ovr}, 32'h0, "before update");
        tester.fin();
        settle();
        chk({31'h0, ovr}, 32'h1, "extest on");
        chk({16'h0, drv}, 32'h3C96, "preload drive");
        set_pins(16'h5AA5);
        dr(20, 32'hF1234);
        chk({12'h0, r[19:0]}, 32'hF5AA5, "extest capture");
        chk({16'h0, drv}, 32'h1234, "extest drive");
        $display("test sample and extest done");
    endtask

    task automatic t_samplez();
        @(posedge ref_clk) clk_en <= 1'b0;
        load(3'h2);
        settle();
        chk({30'h0, ovr, hiz}, 32'h2, "frozen by enable");
        @(posedge ref_clk) clk_en <= 1'b1;
        settle();
        chk({30'h0, ovr, hiz}, 32'h1, "float");
        dr(20, 32'h0);
        chk({12'h0, r[19:0]}, 32'hF5AA5, "samplez shift");
        $display("test samplez done");
    endtask

    task automatic t_undriven();
        @(posedge ref_clk) tms_drv <= 1'b0;
        repeat (5) tester.step(1'b0, 1'b0, b);
        @(posedge ref_clk) tms_drv <= 1'b1;
        tester.step(1'b0, 1'b0, b);
        dr(32, 32'h0);
        chk(r, sbr_pkg::ID_VALUE, "reset by ones");
        chk({30'h0, ovr, hiz}, 32'h0, "reset outputs");
        @(posedge ref_clk) tdi_drv <= 1'b0;
        load(3'h0);
        dr(8, 32'h0);
        chk({24'h0, r[7:0]}, 32'hFE, "undriven data");
        $display("test undriven done");
    endtask

    // ------------------------------------
    // Run control
    // ------------------------------------
    task automatic end_sim();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #400000;
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_sim();
    end

    initial
    begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        tms_drv = 1'b1;
        tdi_drv = 1'b1;
        pins = 16'h0;
        bad_count = 0;
        compares = 0;
        tester.step(1'b1, 1'b1, b);
        tester.step(1'b1, 1'b1, b);
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle();
        tester.step(1'b0, 1'b1, b);
        t_id();
        t_bypass();
        t_sample_extest();
        t_samplez();
        t_undriven();
        end_sim();
    end
endmodule
`default_nettype wire
